// *** dct_datapath.sv ***
`default_nettype none
// Notes on behaviour
// - Select code 11 input, 10 offset, 01 gain, 00 special-function space.
// - Each 12-bit word loads into the addressed channel's chosen register.
// - Every one of forty channels owns its own gain and offset word.
// - Trimmed = input*(gain+2)/4096 + offset - 2048, twelve-bit resolution.
// - Gain uses bits 11..1, bit 0 zero; gain resets to ffe.
// - Offset is twelve bits and resets to 800, meaning no offset.
// - Input code is straight binary, zero to 4095/4096 of full scale.
// - Offset word is offset binary: 000 -2048, 800 zero, fff +2047.
// - Gain ffe is unity, bfe 0.75, 7fe 0.5, 3fe 0.25, 000 is 2/4096.
// - Trimmed codes are double-buffered and all load together on the strobe.
// - One bit picks internal or external reference; another picks level when internal.
// - While busy is low, writes and load strobes are ignored.
module dct_datapath
#(
   parameter int RESET_CYCLES_P = dct_pkg::RESET_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Host write port
   input wire logic write_strobe,
   input wire logic [dct_pkg::CH_ADDR_W-1:0] channel_addr,
   input wire logic select_high_bit,
   input wire logic select_low_bit,
   input wire logic [dct_pkg::DATA_W-1:0] data_word,
   // Digital reset request and simultaneous load
   input wire logic reset_request,
   input wire logic simultaneous_load_strobe,
   // Status
   output logic busy_n,
   // Converter codes, channel n in bits 12n+11..12n
   output logic [dct_pkg::CHANNELS*dct_pkg::DATA_W-1:0] dac_code,
   // Reference selection
   output logic ref_source_select,
   output logic ref_level_select
);
   import dct_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [CHANNELS-1:0][11:0] input_word;
      logic [CHANNELS-1:0][11:0] gain_trim;
      logic [CHANNELS-1:0][11:0] offset_trim;
      logic [CHANNELS-1:0][11:0] trimmed_word;
      logic [CHANNELS-1:0][11:0] dac_word;
      logic pend;
      logic [CH_ADDR_W-1:0] pend_ch;
      logic busy_n;
      logic [BUSY_CNT_W-1:0] busy_cnt;
      logic ref_source;
      logic ref_level;
   } dct_state_s;

   dct_state_s st_q;
   dct_state_s st_d;
   logic [1:0] sel;
   logic accept;
   logic chan_ok;
   logic start_reset;
   dct_trim_if trim_bus ();

   // ------------------------------------------------------------
   // Trim engine
   // ------------------------------------------------------------
   // One shared engine, time-multiplexed by the pending channel
   dct_trim_engine u_trim
   (
      .trim (trim_bus.engine)
   );

   // Feed the engine with the coefficients of the channel last written
   always_comb
   begin
      trim_bus.input_word = st_q.input_word[st_q.pend_ch];
      trim_bus.gain_trim = st_q.gain_trim[st_q.pend_ch];
      trim_bus.offset_trim = st_q.offset_trim[st_q.pend_ch];
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   // Writes are taken only while not busy; out-of-range channels fall away
   always_comb
   begin
      sel = {select_high_bit, select_low_bit};
      chan_ok = channel_addr <= LAST_CHANNEL;
      accept = write_strobe && st_q.busy_n;
      start_reset = st_q.busy_n && (reset_request ||
                    (accept && sel == SEL_SPECIAL && channel_addr == SFR_SOFT_RESET));
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      st_d.pend = 1'b0;
      // Trimmed word lands one cycle after its source register changed
      if (st_q.pend)
      begin
         st_d.trimmed_word[st_q.pend_ch] = trim_bus.trimmed_word;
      end
      // Host writes steer by select code
      if (accept && chan_ok && sel != SEL_SPECIAL)
      begin
         case (sel)
            SEL_INPUT: st_d.input_word[channel_addr] = data_word;
            SEL_OFFSET: st_d.offset_trim[channel_addr] = data_word;
            SEL_GAIN: st_d.gain_trim[channel_addr] = {data_word[11:1], 1'b0};
            default: st_d.pend = 1'b0;
         endcase
         st_d.pend = 1'b1;
         st_d.pend_ch = channel_addr;
      end
      // Control word: only the reference bits live in this block
      if (accept && sel == SEL_SPECIAL && channel_addr == SFR_CTRL_WRITE)
      begin
         st_d.ref_source = data_word[CTRL_REF_SOURCE_BIT];
         st_d.ref_level = data_word[CTRL_REF_LEVEL_BIT];
      end
      // Load all channels at once from the second buffer
      if (simultaneous_load_strobe && st_q.busy_n)
      begin
         st_d.dac_word = st_q.trimmed_word;
      end
      // Reset sequence: registers to defaults, busy low for the full time
      if (start_reset)
      begin
         st_d.input_word = {CHANNELS{INPUT_RESET}};
         st_d.gain_trim = {CHANNELS{GAIN_RESET}};
         st_d.offset_trim = {CHANNELS{OFFSET_RESET}};
         st_d.trimmed_word = {CHANNELS{TRIMMED_RESET}};
         st_d.dac_word = {CHANNELS{TRIMMED_RESET}};
         st_d.pend = 1'b0;
         st_d.busy_n = 1'b0;
         st_d.busy_cnt = BUSY_CNT_W'(RESET_CYCLES_P - 1);
         st_d.ref_source = REF_SOURCE_RESET;
         st_d.ref_level = REF_LEVEL_RESET;
      end
      else if (!st_q.busy_n)
      begin
         if (st_q.busy_cnt == '0)
            st_d.busy_n = 1'b1;
         else
            st_d.busy_cnt = st_q.busy_cnt - 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         st_q.input_word <= {CHANNELS{INPUT_RESET}};
         st_q.gain_trim <= {CHANNELS{GAIN_RESET}};
         st_q.offset_trim <= {CHANNELS{OFFSET_RESET}};
         st_q.trimmed_word <= {CHANNELS{TRIMMED_RESET}};
         st_q.dac_word <= {CHANNELS{TRIMMED_RESET}};
         st_q.pend <= 1'b0;
         st_q.pend_ch <= '0;
         st_q.busy_n <= 1'b1;
         st_q.busy_cnt <= '0;
         st_q.ref_source <= REF_SOURCE_RESET;
         st_q.ref_level <= REF_LEVEL_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Outputs straight from state flops; level applies only with internal reference
   always_comb
   begin
      busy_n = st_q.busy_n;
      dac_code = st_q.dac_word;
      ref_source_select = st_q.ref_source;
      ref_level_select = st_q.ref_level;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_select_route;
      accept && !start_reset && sel == SEL_SPECIAL |=> !st_q.pend;
   endproperty
   a_select_route: assert property (p_select_route) else $error("special space started a trim");

   property p_bus_accept;
      accept && !start_reset && chan_ok && sel == SEL_INPUT
         |=> st_q.pend && st_q.input_word[st_q.pend_ch] == $past(data_word);
   endproperty
   a_bus_accept: assert property (p_bus_accept) else $error("input word not stored");

   property p_gain_store;
      accept && !start_reset && chan_ok && sel == SEL_GAIN
         |=> st_q.gain_trim[st_q.pend_ch] == {$past(data_word[11:1]), 1'b0};
   endproperty
   a_gain_store: assert property (p_gain_store) else $error("gain word wrong");

   property p_reset_defaults;
      start_reset |=> st_q.gain_trim[0] == GAIN_RESET && st_q.offset_trim[0] == OFFSET_RESET
         && st_q.dac_word[0] == TRIMMED_RESET;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

   property p_unity_trim;
      st_q.pend && !start_reset && trim_bus.gain_trim == GAIN_RESET && trim_bus.offset_trim == OFFSET_RESET
         |=> st_q.trimmed_word[$past(st_q.pend_ch)] == $past(trim_bus.input_word);
   endproperty
   a_unity_trim: assert property (p_unity_trim) else $error("unity trim altered code");

   property p_offset_only;
      trim_bus.gain_trim == 12'h000 && !trim_bus.offset_trim[11]
         |-> trim_bus.trimmed_word == 12'h000;
   endproperty
   a_offset_only: assert property (p_offset_only) else $error("negative offset not clamped");

   property p_half_gain;
      trim_bus.gain_trim == 12'h7fe && trim_bus.offset_trim == OFFSET_RESET
         |-> trim_bus.trimmed_word == {1'b0, trim_bus.input_word[11:1]};
   endproperty
   a_half_gain: assert property (p_half_gain) else $error("half gain wrong");

   property p_clamp_high;
      trim_bus.gain_trim == GAIN_RESET && trim_bus.offset_trim == CODE_MAX && trim_bus.input_word == CODE_MAX
         |-> trim_bus.trimmed_word == CODE_MAX;
   endproperty
   a_clamp_high: assert property (p_clamp_high) else $error("overflow not clamped");

   property p_load;
      simultaneous_load_strobe && st_q.busy_n && !start_reset |=> dac_code == $past(st_q.trimmed_word);
   endproperty
   a_load: assert property (p_load) else $error("load strobe missed");

   property p_hold_without_load;
      !simultaneous_load_strobe && !start_reset |=> $stable(dac_code);
   endproperty
   a_hold_without_load: assert property (p_hold_without_load) else $error("outputs moved without load");

   property p_busy_ignore;
      !busy_n && (simultaneous_load_strobe || write_strobe) |=> $stable(dac_code) && !st_q.pend;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("activity taken while busy");

   property p_busy_hold;
      start_reset |=> !busy_n [*2];
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy too short");

   property p_ref_bits;
      accept && !start_reset && sel == SEL_SPECIAL && channel_addr == SFR_CTRL_WRITE
         |=> ref_source_select == $past(data_word[CTRL_REF_SOURCE_BIT])
         && ref_level_select == $past(data_word[CTRL_REF_LEVEL_BIT]);
   endproperty
   a_ref_bits: assert property (p_ref_bits) else $error("reference bits not written");

   property p_offset_store;
      accept && !start_reset && chan_ok && sel == SEL_OFFSET
         |=> st_q.offset_trim[st_q.pend_ch] == $past(data_word);
   endproperty
   a_offset_store: assert property (p_offset_store) else $error("offset word wrong");

   property p_refused_channel;
      accept && !start_reset && !chan_ok && sel != SEL_SPECIAL |=> !st_q.pend;
   endproperty
   a_refused_channel: assert property (p_refused_channel) else $error("absent channel took a write");

   property p_quarter_gain;
      trim_bus.gain_trim == 12'h3fe && trim_bus.offset_trim == OFFSET_RESET
         |-> trim_bus.trimmed_word == {2'h0, trim_bus.input_word[11:2]};
   endproperty
   a_quarter_gain: assert property (p_quarter_gain) else $error("quarter gain wrong");

   property p_zero_gain;
      trim_bus.gain_trim == 12'h000 && trim_bus.offset_trim == OFFSET_RESET
         |-> trim_bus.trimmed_word == {11'h000, trim_bus.input_word[11]};
   endproperty
   a_zero_gain: assert property (p_zero_gain) else $error("zero gain wrong");

   property p_reset_refs;
      start_reset |=> !busy_n && ref_source_select == REF_SOURCE_RESET
         && ref_level_select == REF_LEVEL_RESET;
   endproperty
   a_reset_refs: assert property (p_reset_refs) else $error("reference bits kept over reset");

   property p_busy_count;
      start_reset |=> st_q.busy_cnt == BUSY_CNT_W'(RESET_CYCLES_P - 1);
   endproperty
   a_busy_count: assert property (p_busy_count) else $error("busy count not loaded");

   property p_busy_count_down;
      !st_q.busy_n && st_q.busy_cnt != '0 |=> !busy_n && st_q.busy_cnt == $past(st_q.busy_cnt) - 1'b1;
   endproperty
   a_busy_count_down: assert property (p_busy_count_down) else $error("busy count skipped a step");

   property p_busy_release;
      !st_q.busy_n && st_q.busy_cnt == '0 |=> busy_n;
   endproperty
   a_busy_release: assert property (p_busy_release) else $error("busy not released");
endmodule : dct_datapath
`default_nettype wire

// *** dct_host_model.sv ***
`default_nettype none
// -----------------------------------------------------------
// Host side of the parallel write port
// -----------------------------------------------------------
module dct_host_model
(
   // Clock
   input wire logic clk,
   // Host write port
   output var logic write_strobe,
   output var logic [dct_pkg::CH_ADDR_W-1:0] channel_addr,
   output var logic select_high_bit,
   output var logic select_low_bit,
   output var logic [dct_pkg::DATA_W-1:0] data_word,
   // Reset request and load
   output var logic reset_request,
   output var logic simultaneous_load_strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   import dct_pkg::*;

   // Idle levels from time zero
   initial
   begin
      write_strobe = 1'b0;
      channel_addr = 6'h00;
      {select_high_bit, select_low_bit} = 2'h0;
      data_word = 12'h000;
      reset_request = 1'b0;
      simultaneous_load_strobe = 1'b0;
   end

   // One word per call; released address and data lines show the inverse so stale data never looks valid
   task automatic write_word(input logic [5:0] ch, input logic [1:0] sel, input logic [11:0] d);
      @(negedge clk);
      write_strobe = 1'b1;
      channel_addr = ch;
      {select_high_bit, select_low_bit} = sel;
      data_word = (sel == SEL_GAIN) ? {d[11:1], 1'b0} : d;
      @(negedge clk);
      write_strobe = 1'b0;
      channel_addr = ~ch;
      data_word = ~data_word;
   endtask : write_word

   // One-cycle pulse of the load strobe or of the reset request
   task automatic pulse(input logic is_load);
      @(negedge clk);
      if (is_load)
         simultaneous_load_strobe = 1'b1;
      else
         reset_request = 1'b1;
      @(negedge clk);
      simultaneous_load_strobe = 1'b0;
      reset_request = 1'b0;
   endtask : pulse
endmodule : dct_host_model
`default_nettype wire

// *** dct_pkg.sv ***
`default_nettype none
package dct_pkg;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int CHANNELS = 40;
   localparam int DATA_W = 12;
   localparam int CH_ADDR_W = 6;
   localparam logic [5:0] LAST_CHANNEL = 6'h27;

   // ------------------------------------------------------------
   // Register-select codes
   // ------------------------------------------------------------
   localparam logic [1:0] SEL_INPUT = 2'h3;
   localparam logic [1:0] SEL_OFFSET = 2'h2;
   localparam logic [1:0] SEL_GAIN = 2'h1;
   localparam logic [1:0] SEL_SPECIAL = 2'h0;

   // ------------------------------------------------------------
   // Special-function addresses and control bit positions
   // ------------------------------------------------------------
   localparam logic [5:0] SFR_CTRL_WRITE = 6'h0c;
   localparam logic [5:0] SFR_SOFT_RESET = 6'h0f;
   localparam int CTRL_REF_SOURCE_BIT = 8;
   localparam int CTRL_REF_LEVEL_BIT = 10;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [11:0] INPUT_RESET = 12'h000;
   localparam logic [11:0] GAIN_RESET = 12'hffe;
   localparam logic [11:0] OFFSET_RESET = 12'h800;
   localparam logic [11:0] TRIMMED_RESET = 12'h000;
   localparam logic REF_SOURCE_RESET = 1'b0;
   localparam logic REF_LEVEL_RESET = 1'b1;

   // ------------------------------------------------------------
   // Arithmetic constants
   // ------------------------------------------------------------
   localparam logic [12:0] GAIN_BIAS = 13'h0002;
   localparam logic [14:0] OFFSET_ZERO = 15'h0800;
   localparam logic [11:0] CODE_MAX = 12'hfff;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int RESET_TIME_NS = 270000;
   localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_CNT_W = 16;
endpackage : dct_pkg
`default_nettype wire

// *** dct_trim_engine.sv ***
`default_nettype none
module dct_trim_engine
(
   // Coefficients in, trimmed code out
   dct_trim_if.engine trim
);
   import dct_pkg::*;

   // ------------------------------------------------------------
   // Trim arithmetic
   // ------------------------------------------------------------
   // Gain plus two over 4096, then offset binary around mid-scale
   function automatic logic [11:0] dct_trim_calc(input logic [11:0] code, input logic [11:0] gain,
                                                 input logic [11:0] offset);
      logic [24:0] prod;
      logic [14:0] sum;
      prod = 25'(code) * 25'({1'b0, gain} + GAIN_BIAS);
      sum = {2'h0, prod[24:12]} + {3'h0, offset} - OFFSET_ZERO;
      // Top bit set means the sum went below zero; wrap is impossible in 15 bits
      if (sum[14])
         dct_trim_calc = 12'h000;
      else if (sum[13:12] != 2'h0)
         dct_trim_calc = CODE_MAX;
      else
         dct_trim_calc = sum[11:0];
   endfunction : dct_trim_calc

   // Pure combinational: the caller registers the result
   always_comb
   begin
      trim.trimmed_word = dct_trim_calc(trim.input_word, trim.gain_trim, trim.offset_trim);
   end
endmodule : dct_trim_engine
`default_nettype wire

// *** dct_trim_if.sv ***
`default_nettype none
// Carries one channel's coefficients to the trim engine and the result back
interface dct_trim_if;
   logic [11:0] input_word;
   logic [11:0] gain_trim;
   logic [11:0] offset_trim;
   logic [11:0] trimmed_word;
   modport requester (output input_word, output gain_trim, output offset_trim, input trimmed_word);
   modport engine (input input_word, input gain_trim, input offset_trim, output trimmed_word);
endinterface : dct_trim_if
`default_nettype wire

// *** test_dac_code_trim_datapath.sv ***
`default_nettype none
module test_dac_code_trim_datapath;
   timeunit 1ns;
   timeprecision 1ns;
   import dct_pkg::*;
   // Short busy count keeps the reset sequence quick
   localparam int N_BUSY = 12;
   logic clk, reset, write_strobe, select_high_bit, select_low_bit;
   logic reset_request, simultaneous_load_strobe, busy_n, ref_source_select, ref_level_select;
   logic [5:0] channel_addr;
   logic [11:0] data_word;
   logic [479:0] dac_code;
   logic [11:0] exp_in [CHANNELS];
   logic [11:0] exp_gain [CHANNELS];
   logic [11:0] exp_off [CHANNELS];
   logic [479:0] exp_q [$];
   logic pend;
   logic [31:0] seed;
   int errors;
   int checked;

   dct_datapath #(.RESET_CYCLES_P(N_BUSY)) i_dut (.clk(clk), .reset(reset), .write_strobe(write_strobe),
      .channel_addr(channel_addr), .select_high_bit(select_high_bit), .select_low_bit(select_low_bit),
      .data_word(data_word), .reset_request(reset_request), .simultaneous_load_strobe(simultaneous_load_strobe),
      .busy_n(busy_n), .dac_code(dac_code), .ref_source_select(ref_source_select),
      .ref_level_select(ref_level_select));
   dct_host_model i_host (.clk(clk), .write_strobe(write_strobe), .channel_addr(channel_addr),
      .select_high_bit(select_high_bit), .select_low_bit(select_low_bit), .data_word(data_word),
      .reset_request(reset_request), .simultaneous_load_strobe(simultaneous_load_strobe));

   // -----------------------------------------------------------
   // Reference arithmetic and helpers
   // -----------------------------------------------------------
   function automatic logic [11:0] trim(input logic [11:0] x, input logic [11:0] m, input logic [11:0] c);
      int v;
      v = ((int'(x) * (int'(m) + 2)) >>> 12) + int'(c) - 2048;
      return (v < 0) ? 12'h000 : (v > 4095) ? 12'hfff : v[11:0];
   endfunction : trim

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check_value(input logic [479:0] seen, input logic [479:0] expv, input string what);
      checked++;
      if (seen !== expv)
      begin
         errors++;
         $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, expv);
      end
   endtask : check_value

   task automatic set_defaults();
      for (int i = 0; i < CHANNELS; i++)
      begin
         exp_in[i] = 12'h000;
         exp_gain[i] = 12'hffe;
         exp_off[i] = 12'h800;
      end
   endtask : set_defaults

   // Accepted write: host model drives it, bench notes the new register contents
   task automatic wr(input logic [5:0] ch, input logic [1:0] sel, input logic [11:0] d);
      i_host.write_word(ch, sel, d);
      if (sel == SEL_INPUT) exp_in[ch] = d;
      if (sel == SEL_OFFSET) exp_off[ch] = d;
      if (sel == SEL_GAIN) exp_gain[ch] = {d[11:1], 1'b0};
   endtask : wr

   // Notes the whole expected vector, then strobes; the monitor compares it
   task automatic load();
      logic [479:0] v;
      for (int i = 0; i < CHANNELS; i++) v[i*12 +: 12] = trim(exp_in[i], exp_gain[i], exp_off[i]);
      exp_q.push_back(v);
      i_host.pulse(1'b1);
   endtask : load

   // Counts negedges with busy low, starting from start, the number already seen
   task automatic await_ready(input int start);
      int cnt;
      cnt = start;
      while (busy_n === 1'b0 && cnt < 50)
      begin
         @(negedge clk);
         cnt++;
      end
      check_value(cnt, N_BUSY + 1, "busy length");
   endtask : await_ready

   task automatic complete_run();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   // -----------------------------------------------------------
   // Clock, monitor and watchdog
   // -----------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Sample the strobe before the edge updates busy, so ignored strobes expect nothing
   always @(posedge clk) pend <= (simultaneous_load_strobe === 1'b1) && (busy_n === 1'b1);
   always @(negedge clk)
   begin
      if (pend && exp_q.size() == 0)
         check_value(1'b1, 1'b0, "unexpected load");
      else if (pend)
         check_value(dac_code, exp_q.pop_front(), "dac_code");
   end

   initial
   begin
      #500000;
      errors++;
      $display("ERROR at %0t: watchdog expired", $time);
      complete_run();
   end

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   initial
   begin
      logic [11:0] gains [5];
      int base;
      gains = '{12'hffe, 12'hbfe, 12'h7fe, 12'h3fe, 12'h000};
      reset = 1'b1;
      errors = 0;
      checked = 0;
      seed = 32'h5049fdb1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      check_value({ref_source_select, ref_level_select, busy_n}, 3'h3, "reset outputs");
      set_defaults();
      load();
      $display("test reset done");
      wr(6'h27, SEL_INPUT, 12'habc);
      for (int k = 0; k < 5; k++)
      begin
         wr(6'(k + 1), SEL_INPUT, 12'hfff);
         wr(6'(k + 1), SEL_GAIN, gains[k]);
      end
      wr(6'h06, SEL_INPUT, 12'h010);
      wr(6'h06, SEL_OFFSET, 12'h000);
      wr(6'h07, SEL_INPUT, 12'hfff);
      wr(6'h07, SEL_OFFSET, 12'hfff);
      wr(6'h08, SEL_OFFSET, 12'h801);
      wr(6'h05, SEL_OFFSET, 12'h7ff);
      i_host.write_word(6'h28, SEL_INPUT, 12'h555);
      check_value(dac_code, 0, "unloaded");
      load();
      $display("test trim done");
      for (int k = 0; k < 30; k++)
      begin
         seed = lfsr(seed);
         wr(6'(seed[7:0] % 40), (seed[9:8] == 2'h0) ? SEL_INPUT : seed[9:8], seed[27:16]);
         if (k % 6 == 5) load();
      end
      $display("test random done");
      for (int k = 0; k < 4; k++)
      begin
         base = k;
         wr(SFR_CTRL_WRITE, SEL_SPECIAL, 12'(((base & 1) << 8) | ((base >> 1) << 10)));
         check_value({ref_source_select, ref_level_select}, 2'(base[0] * 2 + base[1]), "ref");
      end
      $display("test control done");
      i_host.pulse(1'b0);
      check_value(busy_n, 1'b0, "reset busy");
      check_value(dac_code, 0, "reset start");
      i_host.write_word(6'h05, SEL_INPUT, 12'hfff);
      i_host.pulse(1'b1);
      await_ready(5);
      set_defaults();
      load();
      wr(6'h02, SEL_INPUT, 12'h123);
      wr(SFR_SOFT_RESET, SEL_SPECIAL, 12'h000);
      check_value(busy_n, 1'b0, "soft reset");
      await_ready(1);
      set_defaults();
      load();
      check_value({ref_source_select, ref_level_select}, 2'h1, "ref after reset");
      $display("test busy done");
      complete_run();
   end
endmodule : test_dac_code_trim_datapath
`default_nettype wire
